// ---- rtl/amc_map.vh ----
// register offsets, field positions, reset values for the mode config block
`ifndef AMC_MAP_VH
`define AMC_MAP_VH
`define AMC_ADDR_MODE 4'h0
`define AMC_ADDR_STATUS 4'h4
`define AMC_ADDR_IRQ_STAT 4'h8
`define AMC_ADDR_IRQ_MASK 4'hc
`define AMC_MODE_RESET 16'h0510
`define AMC_MODE_WMASK 16'h3f1f
`define AMC_BIT_REG_CRC 13
`define AMC_BIT_RX_CRC 12
`define AMC_BIT_CRC_SEL 11
`define AMC_BIT_RST_SEEN 10
`define AMC_WLEN_HI 9
`define AMC_WLEN_LO 8
`define AMC_BIT_TIMEOUT 4
`define AMC_DRS_HI 3
`define AMC_DRS_LO 2
`define AMC_BIT_DR_HIZ 1
`define AMC_BIT_DR_FMT 0
`define AMC_WLEN_16 2'h0
`define AMC_WLEN_24 2'h1
`define AMC_WLEN_32Z 2'h2
`define AMC_WLEN_32S 2'h3
`define AMC_IRQ_RST_CLR 0
`define AMC_IRQ_CFG_WR 1
`endif

// ---- rtl/amc_mode_config.v ----
// mode configuration register bank with wishbone slave and interrupt
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "amc_map.vh"
// How it works
// - bit 13 enables register-map checksum, reset 0
// - bit 12 enables incoming frame checksum, reset 0
// - bit 11 picks checksum polynomial, 0 ccitt
// - bit 10 set after every reset
// - writing 0 clears flag and status mirror
// - bits 9:8 select output word format
// - bit 4 timeout enable, resets to 1
// - status register mirrors reset-occurred flag
module amc_mode_config (
  input wire clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  input wire [23:0] sample_in,
  output reg [31:0] sample_word,
  output reg [5:0] sample_bits,
  output reg reg_crc_en,
  output reg rx_crc_en,
  output reg crc_ansi_sel,
  output reg timeout_en,
  output reg [1:0] data_ready_source_select,
  output reg data_ready_high_impedance,
  output reg data_ready_format,
  output reg irq
);
  // two event sources: reset-flag clear and any write to the mode register
  localparam IRQ_N = 2;
  // byte lanes of the 16-bit mode register
  localparam LANE_LO = 0;
  localparam LANE_HI = 1;
  // bus answer tracker, one-hot
  localparam ST_IDLE = 2'b01;
  localparam ST_RESP = 2'b10;

  reg [15:0] mode_r;
  reg [15:0] mode_nxt;
  reg [IRQ_N-1:0] irq_stat_r;
  wire [IRQ_N-1:0] irq_stat_nxt;
  reg [IRQ_N-1:0] irq_mask_r;
  wire [IRQ_N-1:0] irq_mask_nxt;
  reg [1:0] bus_state_r;
  reg [1:0] bus_state_nxt;
  wire [31:0] fmt_word;
  wire [5:0] fmt_bits;
  wire req;
  wire wr_mode;
  wire rst_clr_ev;
  wire [IRQ_N-1:0] irq_set;
  wire stat_wr;
  wire mask_wr;
  wire [7:0] lo_lane;
  wire [7:0] hi_lane;
  wire bus_hit;
  wire bus_miss;
  wire bus_rd;
  wire irq_nxt;
  reg [31:0] rd_data;
  reg hit;
  genvar gi;

  function addr_ok;
    input [3:0] a;
    begin
      addr_ok = (a == `AMC_ADDR_MODE) || (a == `AMC_ADDR_STATUS) ||
        (a == `AMC_ADDR_IRQ_STAT) || (a == `AMC_ADDR_IRQ_MASK);
    end
  endfunction

  // byte lane update, shared by both halves of the mode register
  function [7:0] lane_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] keep_m;
    input en;
    begin
      if (en) begin
        lane_merge = new_v & keep_m;
      end else begin
        lane_merge = old_v;
      end
    end
  endfunction

  // status view: crc type, reset flag and word length, rest reads zero
  function [31:0] status_word;
    input [15:0] m;
    begin
      status_word = {16'h0000, 4'h0, m[`AMC_BIT_CRC_SEL], m[`AMC_BIT_RST_SEEN],
        m[`AMC_WLEN_HI:`AMC_WLEN_LO], 8'h00};
    end
  endfunction

  // a request is taken only in idle, so a strobe held through ack is not retaken
  always @* begin
    case (bus_state_r)
      ST_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          bus_state_nxt = ST_RESP;
        end else begin
          bus_state_nxt = ST_IDLE;
        end
      end
      ST_RESP: begin
        bus_state_nxt = ST_IDLE;
      end
      default: begin
        bus_state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      bus_state_r <= ST_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  assign req = wb_cyc_i && wb_stb_i && (bus_state_r == ST_IDLE);
  assign bus_hit = req && hit;
  assign bus_miss = req && !hit;
  assign bus_rd = bus_hit && !wb_we_i;
  assign wr_mode = req && wb_we_i && (wb_adr_i == `AMC_ADDR_MODE);
  assign stat_wr = req && wb_we_i && wb_sel_i[LANE_LO] && (wb_adr_i == `AMC_ADDR_IRQ_STAT);
  assign mask_wr = req && wb_we_i && wb_sel_i[LANE_LO] && (wb_adr_i == `AMC_ADDR_IRQ_MASK);
  // flag falls only when software writes the high byte lane (bits 15:8) of the mode register
  assign rst_clr_ev = wr_mode && wb_sel_i[LANE_HI] && mode_r[`AMC_BIT_RST_SEEN] &&
    !wb_dat_i[`AMC_BIT_RST_SEEN];

  amc_word_fmt amc_word_fmt_inst (
    .word_length_select(mode_r[`AMC_WLEN_HI:`AMC_WLEN_LO]),
    .sample_in(sample_in),
    .word_out(fmt_word),
    .word_bits(fmt_bits)
  );

  // reserved bits 15:14 and 7:5 never take a one, whatever the host writes
  assign lo_lane = lane_merge(mode_r[7:0], wb_dat_i[7:0], 8'h1f, wb_sel_i[LANE_LO]);
  assign hi_lane = lane_merge(mode_r[15:8], wb_dat_i[15:8], 8'h3f, wb_sel_i[LANE_HI]);

  always @* begin
    mode_nxt = mode_r;
    if (wr_mode) begin
      mode_nxt[7:0] = lo_lane;
      mode_nxt[15:8] = hi_lane;
      if (wb_sel_i[LANE_HI]) begin
        // writing 1 cannot fake a reset event
        mode_nxt[`AMC_BIT_RST_SEEN] = mode_r[`AMC_BIT_RST_SEEN] &
          wb_dat_i[`AMC_BIT_RST_SEEN];
      end
    end
  end

  // event sources of the sticky status bits
  assign irq_set[`AMC_IRQ_RST_CLR] = rst_clr_ev;
  assign irq_set[`AMC_IRQ_CFG_WR] = wr_mode;

  // per bit: an event wins over a write-one clear in the same cycle
  generate
    for (gi = 0; gi < IRQ_N; gi = gi + 1) begin : g_irq
      assign irq_stat_nxt[gi] = irq_set[gi] |
        (irq_stat_r[gi] & ~(stat_wr & wb_dat_i[gi]));
      assign irq_mask_nxt[gi] = mask_wr ? wb_dat_i[gi] : irq_mask_r[gi];
    end
  endgenerate

  // level output follows the next state so it moves with its status bit
  assign irq_nxt = |(irq_stat_nxt & irq_mask_nxt);

  always @* begin
    hit = addr_ok(wb_adr_i);
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `AMC_ADDR_MODE: begin
        rd_data = {16'h0000, mode_r};
      end
      `AMC_ADDR_STATUS: begin
        // status mirrors the reset flag of the mode register
        rd_data = status_word(mode_r);
      end
      `AMC_ADDR_IRQ_STAT: begin
        rd_data = {{(32-IRQ_N){1'b0}}, irq_stat_r};
      end
      `AMC_ADDR_IRQ_MASK: begin
        rd_data = {{(32-IRQ_N){1'b0}}, irq_mask_r};
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // mode register; only a device reset sets the reset flag again
  always @(posedge clk) begin
    if (!rst_b) begin
      mode_r <= `AMC_MODE_RESET;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // sticky status and mask bits
  always @(posedge clk) begin
    if (!rst_b) begin
      irq_stat_r <= {IRQ_N{1'b0}};
      irq_mask_r <= {IRQ_N{1'b0}};
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // interrupt level, straight from a flop
  always @(posedge clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_nxt;
    end
  end

  // answer rises on the taking edge and lasts one cycle, then idle again
  always @(posedge clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_hit;
      wb_err_o <= bus_miss;
    end
  end

  // read data stands only with ack and is zero otherwise,
  // so a stale word never looks like an answer
  always @(posedge clk) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      if (bus_rd) begin
        wb_dat_o <= rd_data;
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // formatted sample, one cycle behind sample_in
  always @(posedge clk) begin
    if (!rst_b) begin
      sample_word <= 32'h0000_0000;
      sample_bits <= 6'h18;
    end else begin
      sample_word <= fmt_word;
      sample_bits <= fmt_bits;
    end
  end

  // checksum controls taken from the next value so they move with the register
  always @(posedge clk) begin
    if (!rst_b) begin
      reg_crc_en <= 1'b0;
      rx_crc_en <= 1'b0;
      crc_ansi_sel <= 1'b0;
    end else begin
      reg_crc_en <= mode_nxt[`AMC_BIT_REG_CRC];
      rx_crc_en <= mode_nxt[`AMC_BIT_RX_CRC];
      crc_ansi_sel <= mode_nxt[`AMC_BIT_CRC_SEL];
    end
  end

  // timeout is on out of reset
  always @(posedge clk) begin
    if (!rst_b) begin
      timeout_en <= 1'b1;
    end else begin
      timeout_en <= mode_nxt[`AMC_BIT_TIMEOUT];
    end
  end

  // data-ready controls: only stored here, acted on elsewhere
  always @(posedge clk) begin
    if (!rst_b) begin
      data_ready_source_select <= 2'h0;
      data_ready_high_impedance <= 1'b0;
      data_ready_format <= 1'b0;
    end else begin
      data_ready_source_select <= mode_nxt[`AMC_DRS_HI:`AMC_DRS_LO];
      data_ready_high_impedance <= mode_nxt[`AMC_BIT_DR_HIZ];
      data_ready_format <= mode_nxt[`AMC_BIT_DR_FMT];
    end
  end
endmodule

// ---- rtl/amc_word_fmt.v ----
// formats a 24-bit sample to the selected output word length
`timescale 1ns/1ps
`include "amc_map.vh"
module amc_word_fmt (
  input wire [1:0] word_length_select,
  input wire [23:0] sample_in,
  output reg [31:0] word_out,
  output reg [5:0] word_bits
);
  always @* begin
    case (word_length_select)
      `AMC_WLEN_16: begin
        word_out = {16'h0000, sample_in[23:8]};
        word_bits = 6'h10;
      end
      `AMC_WLEN_32Z: begin
        word_out = {sample_in, 8'h00};
        word_bits = 6'h20;
      end
      `AMC_WLEN_32S: begin
        word_out = {{8{sample_in[23]}}, sample_in};
        word_bits = 6'h20;
      end
      default: begin
        word_out = {8'h00, sample_in};
        word_bits = 6'h18;
      end
    endcase
  end
endmodule

// ---- testbench/amc_host.sv ----
// wishbone classic master standing in for the host processor
`timescale 1ns/1ps
module amc_host(
  input wire clk,
  input wire wb_ack_o,
  input wire wb_err_o,
  output logic wb_cyc_i = 1'b0,
  output logic wb_stb_i = 1'b0,
  output logic wb_we_i = 1'b0,
  output logic [3:0] wb_adr_i = 4'h0,
  output logic [3:0] wb_sel_i = 4'h3,
  output logic [31:0] wb_dat_i = 32'h0
);
  task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    // only the bench watchdog ends a wait for the answer
    do @(posedge clk); while (!(wb_ack_o | wb_err_o));
    // released lines must not keep the last value
    {wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} <= {2'h0, ~a, ~d};
  endtask
endmodule

// ---- testbench/amc_mode_checker.sv ----
// assertions on the mode config register bank ports
`timescale 1ns/1ps
module amc_mode_checker(
  input wire clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire reg_crc_en,
  input wire rx_crc_en,
  input wire crc_ansi_sel,
  input wire timeout_en,
  input wire data_ready_format
);
  wire take = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire wm = take & wb_we_i & (wb_adr_i == 4'h0) & (&wb_sel_i[1:0]);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ack_pulse: assert property (take && wb_adr_i[1:0] == 2'h0 |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bad ack");
  a_reg_crc_wr: assert property (wm |=> reg_crc_en == $past(wb_dat_i[13]))
    else $error("bad reg crc");
  a_rx_crc_wr: assert property (wm |=> rx_crc_en == $past(wb_dat_i[12]))
    else $error("bad rx crc");
  a_crc_type_wr: assert property (wm |=> crc_ansi_sel == $past(wb_dat_i[11]))
    else $error("bad crc type");
  a_timeout_wr: assert property (wm |=> timeout_en == $past(wb_dat_i[4]))
    else $error("bad timeout");
  a_format_wr: assert property (wm |=> data_ready_format == $past(wb_dat_i[0]))
    else $error("bad format");
  a_cfg_hold: assert property (!wm |=> $stable({reg_crc_en, rx_crc_en, crc_ansi_sel}))
    else $error("config moved");
  a_reset_vals: assert property ($rose(rst_b) |-> timeout_en && !reg_crc_en && !rx_crc_en)
    else $error("bad reset");
endmodule
bind amc_mode_config amc_mode_checker amc_mode_checker_inst(.*);

// ---- testbench/amc_mode_config_test.sv ----
// self-checking bench for the mode config register bank
`timescale 1ns/1ps
`define CK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module amc_mode_config_test;
  logic clk = 0, rst_b = 0, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, irq;
  logic reg_crc_en, rx_crc_en, crc_ansi_sel, timeout_en, data_ready_high_impedance;
  logic data_ready_format;
  logic [1:0] data_ready_source_select;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, sample_word, rng = 32'h63;
  logic [23:0] sample_in = 24'h0;
  logic [5:0] sample_bits;
  logic [32:0] exp_q[$], e;
  int n_mismatch = 0, checked = 0;
  amc_host amc_host_inst(.*);
  amc_mode_config amc_mode_config_inst(.*);
  always #25 clk = ~clk;
  function logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function logic [31:0] exp_word(input logic [1:0] w, input logic [23:0] x);
    case (w)
      2'h0: return {16'h0, x[23:8]};
      2'h1: return {8'h0, x};
      2'h2: return {x, 8'h0};
      default: return {{8{x[23]}}, x};
    endcase
  endfunction
  task rd(input logic [3:0] a, input logic [32:0] x);
    exp_q.push_back(x);
    amc_host_inst.xfer(1'b0, a, 32'h0);
  endtask
  task test_done;
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) if ((wb_ack_o | wb_err_o) && !wb_we_i) begin
    e = exp_q.pop_front();
    `CK({wb_err_o, wb_dat_o}, e)
  end
  initial begin
    logic [15:0] v;
    logic rs;
    logic [23:0] s;
    rs = 1;
    repeat (16) @(posedge clk);
    rst_b <= 1;
    rd(4'h0, 33'h510);
    rd(4'h4, 33'h500);
    rd(4'h2, 33'h100000000);
    for (int i = 0; i < 8; i++) begin
      // reserved bits kept zero on every write
      v = 16'((xs() & 32'h3cff | i % 4 << 8) & 32'h3f1f);
      amc_host_inst.xfer(1'b1, 4'h0, {16'h0, v});
      rs &= v[10];
      rd(4'h0, {17'h0, v & 16'hfbff | 16'(rs) << 10});
      rd(4'h4, {21'h0, v[11], rs, v[9:8], 8'h0});
      s = 24'(xs());
      sample_in <= s;
      repeat (2) @(posedge clk);
      `CK(sample_bits, 6'(16 + 8 * (i % 4 > 1 ? 2 : i % 4)))
      `CK(sample_word, exp_word(v[9:8], s))
      `CK({data_ready_source_select, data_ready_high_impedance, data_ready_format}, v[3:0])
    end
    amc_host_inst.xfer(1'b1, 4'h0, 32'h10);
    rd(4'h8, 33'h3);
    amc_host_inst.xfer(1'b1, 4'hc, 32'h1);
    @(posedge clk);
    `CK(irq, 1'b1)
    amc_host_inst.xfer(1'b1, 4'h8, 32'h1);
    @(posedge clk);
    `CK(irq, 1'b0)
    rd(4'h8, 33'h2);
    amc_host_inst.xfer(1'b1, 4'h0, 32'hffff_ffff);
    rd(4'h0, 33'h3b1f);
    @(posedge clk);
    rst_b <= 0;
    repeat (16) @(posedge clk);
    rst_b <= 1;
    rd(4'h0, 33'h510);
    rd(4'h4, 33'h500);
    rd(4'h8, 33'h0);
    test_done;
  end
  initial begin
    #150000;
    n_mismatch++;
    test_done;
  end
endmodule
